// *** design/ssp_map.svh ***
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
// Contract
// - Frame holds sixteen bits: command, then data.
// - Second byte is write data, ignored on reads.
// - Sample on rising clock, launch on falling.
// - First byte returns old frame error, parity.
// - Seventh first-byte bit is always one.
// - Odd parity covers the data byte sent.
// - Data byte returns register value before write.
// - Valid writes commit at chip select rise.
// - Read value loaded on eighth rise, MSB first.
// - Data out released while chip select high.
// - Key sequence 00h,50h,A0h opens the lock.
// - Data port reaches selected indirect register, unlocked.
// - Output config per-axis store enables, reset one.
// - Rate field divides buffer load by two/four.
// - Three-quarter buffer interrupt enable, bit seven.
// - Half buffer interrupt enable, bit six.
// - Mask-all bit silences the interrupt pin.
// - Polarity bit selects interrupt pin active level.
// - Thresholds reset 10h, unsigned, trigger motion.
// - Device is slave only, one interface.
// - Bad pulse count flags error, drops command.
// - Five-bit selector chooses indirect register.
`define SSP_ADDR_STATUS 6'h02
`define SSP_ADDR_SELECTOR 6'h18
`define SSP_ADDR_LOCK_KEY 6'h1E
`define SSP_ADDR_INT_MASK 6'h21
`define SSP_ADDR_CTRL_DATA 6'h22
`define SSP_SEL_MOTION_CTRL 5'h02
`define SSP_SEL_THR_Y 5'h03
`define SSP_SEL_THR_X 5'h04
`define SSP_SEL_THR_Z 5'h05
`define SSP_SEL_OUT_CFG 5'h0B
`define SSP_RST_INT_MASK 8'h41
`define SSP_RST_MOTION_CTRL 8'h07
`define SSP_RST_THR 8'h10
`define SSP_RST_OUT_CFG 8'h1C
`define SSP_RST_LOCK_KEY 8'h00
`define SSP_RST_SELECTOR 5'h00
`define SSP_KEY_FIRST 8'h00
`define SSP_KEY_SECOND 8'h50
`define SSP_KEY_THIRD 8'hA0
`define SSP_MASK_TQ_BIT 7
`define SSP_MASK_HALF_BIT 6
`define SSP_MASK_ALL_BIT 1
`define SSP_MASK_POL_BIT 0
`define SSP_OUT_X_BIT 4
`define SSP_OUT_Y_BIT 3
`define SSP_OUT_Z_BIT 2
`define SSP_RATE_DIV4 2'h2
`define SSP_RATE_DIV2 2'h1
`define SSP_FRAME_BITS 6'h10
`define SSP_LOAD_RISE 6'h08
`endif

// *** design/ssp_pkg.sv ***
package ssp_pkg;
  typedef enum logic [1:0] {
    SSP_LK_IDLE = 2'b00,
    SSP_LK_GOT_FIRST = 2'b01,
    SSP_LK_GOT_SECOND = 2'b10,
    SSP_LK_OPEN = 2'b11
  } ssp_lock_t;
endpackage

// *** design/ssp_top.sv ***
`include "ssp_map.svh"

module ssp_top (
  input wire logic core_clk, // Core clock, 125 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic sck, // Serial clock from the host.
  input wire logic chip_select_n, // Frame select, active low.
  input wire logic mosi, // Serial data in.
  output logic miso_o, // Serial data out.
  output logic miso_oe_n, // Serial data out enable, active low.
  input wire logic sample_strobe, // One pulse per new axis sample set.
  input wire logic [7:0] delta_x, // Unsigned X change magnitude.
  input wire logic [7:0] delta_y, // Unsigned Y change magnitude.
  input wire logic [7:0] delta_z, // Unsigned Z change magnitude.
  input wire logic freefall_event, // Free-fall detector level.
  input wire logic buf_half_full, // Ring buffer at least half full.
  input wire logic buf_tq_full, // Ring buffer at least three-quarters full.
  output logic int_pin, // Interrupt pin level.
  output logic motion_irq, // Motion detector hit level.
  output logic buf_store_x, // Store X sample into ring buffer.
  output logic buf_store_y, // Store Y sample into ring buffer.
  output logic buf_store_z // Store Z sample into ring buffer.
);

  // Serial side, clocked by sck.
  logic frame_idle;
  logic fresh_q;
  logic [5:0] cnt_q;
  logic ge16_q;
  logic [15:0] rx_q;
  logic [7:0] tx_q;
  logic frame_tgl_q;
  logic miso_q;
  logic [5:0] addr_live;
  logic [7:0] rd_val;

  // Core side.
  logic cs_meta_q;
  logic cs_sync_q;
  logic cs_prev_q;
  logic tgl_meta_q;
  logic tgl_sync_q;
  logic tgl_seen_q;
  logic frame_end;
  logic frame_ok;
  logic wr_commit;
  logic [5:0] wr_addr;
  logic [7:0] wr_data;
  logic ferr_q;
  ssp_pkg::ssp_lock_t lock_q;
  logic lock_open;
  logic [7:0] lock_key_q;
  logic [7:0] int_mask_q;
  logic [4:0] selector_q;
  logic [7:0] motion_ctrl_q;
  logic [7:0] thr_x_q;
  logic [7:0] thr_y_q;
  logic [7:0] thr_z_q;
  logic [7:0] out_cfg_q;
  logic [7:0] indirect_val;
  logic [7:0] status_val;
  logic ind_write;
  logic [2:0] exceed;
  logic motion_hit;
  logic irq_level;
  logic [1:0] rate_cnt_q;
  logic rate_load;
  logic int_pin_q;
  logic motion_q;
  logic store_x_q;
  logic store_y_q;
  logic store_z_q;

  assign frame_idle = chip_select_n | ~rst_n;

  // Set while the select is high, so the first rise of a frame restarts the count.
  always_ff @(posedge sck or posedge frame_idle) begin
    if (frame_idle) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
      ge16_q <= 1'b0;
      rx_q <= 16'h0000;
    end else if (!chip_select_n) begin
      if (fresh_q) begin
        cnt_q <= 6'h01;
        ge16_q <= 1'b0;
        rx_q <= {15'h0000, mosi};
      end else begin
        cnt_q <= cnt_q + 6'h01;
        if (cnt_q == `SSP_FRAME_BITS - 6'h01) begin
          ge16_q <= 1'b1;
        end
        if (!ge16_q) begin
          rx_q <= {rx_q[14:0], mosi};
        end
      end
    end
  end

  // Marks each frame that saw at least one clock pulse.
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      frame_tgl_q <= 1'b0;
    end else if (!chip_select_n && fresh_q) begin
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // Address bits arrive on rises one to six and sit here from rise seven until rise eight.
  assign addr_live = rx_q[6:1];

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
    end else if (!chip_select_n && !fresh_q && cnt_q == `SSP_LOAD_RISE - 6'h01) begin
      tx_q <= rd_val;
    end
  end

  // Core registers only change after a frame ends, so they are stable while read here.
  always_ff @(negedge sck or posedge frame_idle) begin
    if (frame_idle) begin
      miso_q <= 1'b0;
    end else begin
      case (cnt_q)
        6'h01: miso_q <= ferr_q;
        6'h06: miso_q <= 1'b1;
        6'h07: miso_q <= ~^rd_val;
        6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F: begin
          miso_q <= tx_q[3'(4'hF - cnt_q[3:0])];
        end
        default: miso_q <= 1'b0;
      endcase
    end
  end

  // The port only answers a host clock and never starts a transfer.
  assign miso_o = miso_q;
  assign miso_oe_n = chip_select_n;

  // Frame end seen in the core domain.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_prev_q <= 1'b1;
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
    end else begin
      cs_meta_q <= chip_select_n;
      cs_sync_q <= cs_meta_q;
      cs_prev_q <= cs_sync_q;
      tgl_meta_q <= frame_tgl_q;
      tgl_sync_q <= tgl_meta_q;
    end
  end

  assign frame_end = cs_sync_q & ~cs_prev_q;
  assign frame_ok = (tgl_sync_q != tgl_seen_q) && ge16_q && (cnt_q[2:0] == 3'h0);
  assign wr_addr = rx_q[15:10];
  assign wr_data = rx_q[7:0];
  assign wr_commit = frame_end & frame_ok & rx_q[9];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_seen_q <= 1'b0;
      ferr_q <= 1'b0;
    end else if (frame_end) begin
      tgl_seen_q <= tgl_sync_q;
      ferr_q <= ~frame_ok;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= ssp_pkg::SSP_LK_IDLE;
      lock_key_q <= `SSP_RST_LOCK_KEY;
    end else if (wr_commit && wr_addr == `SSP_ADDR_LOCK_KEY) begin
      lock_key_q <= wr_data;
      case (lock_q)
        ssp_pkg::SSP_LK_GOT_FIRST: begin
          if (wr_data == `SSP_KEY_SECOND) begin
            lock_q <= ssp_pkg::SSP_LK_GOT_SECOND;
          end else if (wr_data == `SSP_KEY_FIRST) begin
            lock_q <= ssp_pkg::SSP_LK_GOT_FIRST;
          end else begin
            lock_q <= ssp_pkg::SSP_LK_IDLE;
          end
        end
        ssp_pkg::SSP_LK_GOT_SECOND: begin
          if (wr_data == `SSP_KEY_THIRD) begin
            lock_q <= ssp_pkg::SSP_LK_OPEN;
          end else if (wr_data == `SSP_KEY_FIRST) begin
            lock_q <= ssp_pkg::SSP_LK_GOT_FIRST;
          end else begin
            lock_q <= ssp_pkg::SSP_LK_IDLE;
          end
        end
        default: begin
          if (wr_data == `SSP_KEY_FIRST) begin
            lock_q <= ssp_pkg::SSP_LK_GOT_FIRST;
          end else begin
            lock_q <= ssp_pkg::SSP_LK_IDLE;
          end
        end
      endcase
    end
  end

  assign lock_open = (lock_q == ssp_pkg::SSP_LK_OPEN);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask_q <= `SSP_RST_INT_MASK;
    end else if (wr_commit && wr_addr == `SSP_ADDR_INT_MASK) begin
      int_mask_q <= {wr_data[7:6], 4'h0, wr_data[1:0]};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      selector_q <= `SSP_RST_SELECTOR;
    end else if (wr_commit && wr_addr == `SSP_ADDR_SELECTOR && lock_open) begin
      selector_q <= wr_data[4:0];
    end
  end

  assign ind_write = wr_commit && wr_addr == `SSP_ADDR_CTRL_DATA && lock_open;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      motion_ctrl_q <= `SSP_RST_MOTION_CTRL;
      thr_x_q <= `SSP_RST_THR;
      thr_y_q <= `SSP_RST_THR;
      thr_z_q <= `SSP_RST_THR;
      out_cfg_q <= `SSP_RST_OUT_CFG;
    end else if (ind_write) begin
      if (selector_q == `SSP_SEL_MOTION_CTRL) begin
        motion_ctrl_q <= {2'h0, wr_data[5:0]};
      end else if (selector_q == `SSP_SEL_THR_X) begin
        thr_x_q <= wr_data;
      end else if (selector_q == `SSP_SEL_THR_Y) begin
        thr_y_q <= wr_data;
      end else if (selector_q == `SSP_SEL_THR_Z) begin
        thr_z_q <= wr_data;
      end else if (selector_q == `SSP_SEL_OUT_CFG) begin
        out_cfg_q <= {3'h0, wr_data[4:0]};
      end
    end
  end

  always_comb begin
    indirect_val = 8'h00;
    if (!lock_open) begin
      indirect_val = 8'h00;
    end else if (selector_q == `SSP_SEL_MOTION_CTRL) begin
      indirect_val = motion_ctrl_q;
    end else if (selector_q == `SSP_SEL_THR_X) begin
      indirect_val = thr_x_q;
    end else if (selector_q == `SSP_SEL_THR_Y) begin
      indirect_val = thr_y_q;
    end else if (selector_q == `SSP_SEL_THR_Z) begin
      indirect_val = thr_z_q;
    end else if (selector_q == `SSP_SEL_OUT_CFG) begin
      indirect_val = out_cfg_q;
    end
  end

  assign status_val = {2'h0, lock_open, 4'h0, ferr_q};

  always_comb begin
    rd_val = 8'h00;
    if (addr_live == `SSP_ADDR_STATUS) begin
      rd_val = status_val;
    end else if (addr_live == `SSP_ADDR_SELECTOR) begin
      rd_val = {3'h0, selector_q};
    end else if (addr_live == `SSP_ADDR_LOCK_KEY) begin
      rd_val = lock_key_q;
    end else if (addr_live == `SSP_ADDR_INT_MASK) begin
      rd_val = int_mask_q;
    end else if (addr_live == `SSP_ADDR_CTRL_DATA) begin
      rd_val = indirect_val;
    end
  end

  // Motion detector: any enabled axis, or all required axes together.
  assign exceed = {delta_z > thr_z_q, delta_x > thr_x_q, delta_y > thr_y_q};
  assign motion_hit = (|(exceed & motion_ctrl_q[2:0])) ||
                      ((motion_ctrl_q[5:3] != 3'h0) &&
                       ((exceed & motion_ctrl_q[5:3]) == motion_ctrl_q[5:3]));

  assign irq_level = motion_q | freefall_event |
                     (buf_half_full & int_mask_q[`SSP_MASK_HALF_BIT]) |
                     (buf_tq_full & int_mask_q[`SSP_MASK_TQ_BIT]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      motion_q <= 1'b0;
      int_pin_q <= 1'b0;
    end else begin
      motion_q <= motion_hit;
      if (int_mask_q[`SSP_MASK_ALL_BIT]) begin
        int_pin_q <= ~int_mask_q[`SSP_MASK_POL_BIT];
      end else begin
        int_pin_q <= irq_level ~^ int_mask_q[`SSP_MASK_POL_BIT];
      end
    end
  end

  // Ring buffer load decimation; the motion detector keeps the full rate.
  always_comb begin
    rate_load = 1'b1;
    if (out_cfg_q[1:0] == `SSP_RATE_DIV4) begin
      rate_load = (rate_cnt_q == 2'h0);
    end else if (out_cfg_q[1:0] == `SSP_RATE_DIV2) begin
      rate_load = ~rate_cnt_q[0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_cnt_q <= 2'h0;
    end else if (sample_strobe) begin
      rate_cnt_q <= rate_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_x_q <= 1'b0;
      store_y_q <= 1'b0;
      store_z_q <= 1'b0;
    end else begin
      store_x_q <= sample_strobe & rate_load & out_cfg_q[`SSP_OUT_X_BIT];
      store_y_q <= sample_strobe & rate_load & out_cfg_q[`SSP_OUT_Y_BIT];
      store_z_q <= sample_strobe & rate_load & out_cfg_q[`SSP_OUT_Z_BIT];
    end
  end

  assign int_pin = int_pin_q;
  assign motion_irq = motion_q;
  assign buf_store_x = store_x_q;
  assign buf_store_y = store_y_q;
  assign buf_store_z = store_z_q;

endmodule

// *** testbench/sensor_spi_register_port_tb_top.sv ***
`include "ssp_map.svh"

module sensor_spi_register_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_strobe = 1'b0;
  logic freefall_event = 1'b0;
  logic buf_half_full = 1'b0;
  logic buf_tq_full = 1'b0;
  logic [7:0] delta_x = 8'h00;
  logic [7:0] delta_y = 8'h00;
  logic [7:0] delta_z = 8'h00;
  logic sck, chip_select_n, mosi, miso_o, miso_oe_n, int_pin, motion_irq;
  logic buf_store_x, buf_store_y, buf_store_z;
  logic [15:0] rx;
  logic [11:0] tbl [8] = '{12'h419, 12'h408, 12'h401, 12'h438, 12'h415, 12'h014, 12'h012,
    12'h813};
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  always #4 core_clk = ~core_clk;
  ssp_host i_host (.sck(sck), .chip_select_n(chip_select_n), .mosi(mosi), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n));
  ssp_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .sck(sck), .chip_select_n(chip_select_n),
    .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .sample_strobe(sample_strobe),
    .delta_x(delta_x), .delta_y(delta_y), .delta_z(delta_z), .freefall_event(freefall_event),
    .buf_half_full(buf_half_full), .buf_tq_full(buf_tq_full), .int_pin(int_pin),
    .motion_irq(motion_irq), .buf_store_x(buf_store_x), .buf_store_y(buf_store_y),
    .buf_store_z(buf_store_z));
  task automatic test_done();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic frm(input logic [5:0] a, input logic w, input logic [7:0] d,
    input logic [7:0] e, input logic fe);
    i_host.xfer({a, w, 1'b0, d}, 16, rx);
    chk_byte(rx[15:8], {1'b0, fe, 4'h0, 1'b1, ~^e});
    chk_byte(rx[7:0], e);
  endtask
  task automatic t_lock();
    frm(`SSP_ADDR_SELECTOR, 1'b1, 8'h0B, 8'h00, 1'b0);
    frm(`SSP_ADDR_CTRL_DATA, 1'b0, 8'h00, 8'h00, 1'b0);
    frm(`SSP_ADDR_LOCK_KEY, 1'b1, 8'h00, 8'h00, 1'b0);
    frm(`SSP_ADDR_LOCK_KEY, 1'b1, 8'h50, 8'h00, 1'b0);
    frm(`SSP_ADDR_LOCK_KEY, 1'b1, 8'hA0, 8'h50, 1'b0);
    frm(`SSP_ADDR_STATUS, 1'b0, 8'h00, 8'h20, 1'b0);
    frm(`SSP_ADDR_SELECTOR, 1'b1, 8'h05, 8'h00, 1'b0);
    frm(`SSP_ADDR_CTRL_DATA, 1'b1, 8'h20, 8'h10, 1'b0);
    frm(`SSP_ADDR_CTRL_DATA, 1'b0, 8'h00, 8'h20, 1'b0);
  endtask
  // Applies one set of axis changes and judges the motion output once it has settled.
  task automatic mot(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z,
    input logic e);
    @(negedge core_clk) {delta_x, delta_y, delta_z} = {x, y, z};
    repeat (3) @(negedge core_clk);
    chk_bit(motion_irq, e);
  endtask
  task automatic t_motion();
    mot(8'h00, 8'h00, 8'h20, 1'b0);
    mot(8'h00, 8'h00, 8'h21, 1'b1);
    chk_bit(int_pin, 1'b1);
    mot(8'h11, 8'h00, 8'h00, 1'b1);
    mot(8'h00, 8'h11, 8'h00, 1'b1);
    frm(`SSP_ADDR_SELECTOR, 1'b1, 8'h02, 8'h05, 1'b0);
    frm(`SSP_ADDR_CTRL_DATA, 1'b1, 8'h18, 8'h07, 1'b0);
    mot(8'h11, 8'h00, 8'h00, 1'b0);
    mot(8'h11, 8'h11, 8'h00, 1'b1);
    frm(`SSP_ADDR_CTRL_DATA, 1'b1, 8'h07, 8'h18, 1'b0);
    frm(`SSP_ADDR_SELECTOR, 1'b1, 8'h05, 8'h02, 1'b0);
    mot(8'h00, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic t_buf();
    int nx;
    int nz;
    int ny;
    logic [7:0] old;
    old = 8'h1C;
    frm(`SSP_ADDR_SELECTOR, 1'b1, 8'h0B, 8'h05, 1'b0);
    frm(`SSP_ADDR_CTRL_DATA, 1'b0, 8'hFF, old, 1'b0);
    for (int r = 0; r < 4; r++) begin
      frm(`SSP_ADDR_CTRL_DATA, 1'b1, {6'h06, r[1:0]}, old, 1'b0);
      old = {6'h06, r[1:0]};
      nx = 0;
      ny = 0;
      nz = 0;
      repeat (8) begin
        @(negedge core_clk) sample_strobe = 1'b1;
        @(negedge core_clk) sample_strobe = 1'b0;
        nx += (buf_store_x === 1'b1);
        ny += (buf_store_y === 1'b1);
        nz += (buf_store_z === 1'b1);
        repeat (2) @(negedge core_clk);
      end
      chk_byte(8'(nx), (r == 2) ? 8'h02 : (r == 1) ? 8'h04 : 8'h08);
      chk_byte(8'(ny), (r == 2) ? 8'h02 : (r == 1) ? 8'h04 : 8'h08);
      chk_byte(8'(nz), 8'h00);
    end
  endtask
  task automatic t_irq();
    logic [7:0] old;
    old = 8'h41;
    foreach (tbl[i]) begin
      frm(`SSP_ADDR_INT_MASK, 1'b1, tbl[i][11:4], old, 1'b0);
      old = tbl[i][11:4];
      @(negedge core_clk) {freefall_event, buf_half_full, buf_tq_full} = tbl[i][3:1];
      repeat (4) @(negedge core_clk);
      chk_bit(int_pin, tbl[i][0]);
    end
    {freefall_event, buf_half_full, buf_tq_full} = 3'h0;
    frm(`SSP_ADDR_INT_MASK, 1'b1, 8'h41, old, 1'b0);
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk_bit(miso_oe_n, 1'b1);
    chk_bit(int_pin, 1'b0);
    frm(`SSP_ADDR_INT_MASK, 1'b0, 8'h5A, 8'h41, 1'b0);
    frm(`SSP_ADDR_LOCK_KEY, 1'b0, 8'h00, 8'h00, 1'b0);
    frm(6'h3F, 1'b0, 8'h00, 8'h00, 1'b0);
    i_host.xfer({`SSP_ADDR_INT_MASK, 2'b10, 8'h00}, 8, rx);
    i_host.xfer({`SSP_ADDR_INT_MASK, 2'b10, 8'h00}, 12, rx);
    frm(`SSP_ADDR_INT_MASK, 1'b0, 8'h00, 8'h41, 1'b1);
    frm(`SSP_ADDR_STATUS, 1'b0, 8'h00, 8'h00, 1'b0);
    t_lock();
    t_motion();
    t_buf();
    t_irq();
    frm(`SSP_ADDR_LOCK_KEY, 1'b1, 8'h33, 8'hA0, 1'b0);
    frm(`SSP_ADDR_STATUS, 1'b0, 8'h00, 8'h00, 1'b0);
    test_done();
  end
endmodule

// *** testbench/ssp_host.sv ***
module ssp_host (
  output logic sck, // Link clock, idle low.
  output logic chip_select_n, // Select, pulled high.
  output logic mosi, // Data out, pulled low.
  input wire logic miso_o, // Data in.
  input wire logic miso_oe_n // Data in enable.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #3 chip_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = tx[15 - (i % 16)];
      #80 sck = 1'b1;
      rx = {rx[14:0], miso_oe_n ? 1'bx : miso_o};
      #80 sck = 1'b0;
    end
    #80 chip_select_n = 1'b1;
    mosi = 1'b0;
    #400;
  endtask
endmodule

// *** testbench/ssp_top_asserts.sv ***
module ssp_top_asserts (
  input wire logic core_clk, // Core clock.
  input wire logic rst_n, // Reset.
  input wire logic sck, // Link clock.
  input wire logic chip_select_n, // Select.
  input wire logic mosi, // Data in.
  input wire logic miso_o, // Data out.
  input wire logic miso_oe_n, // Out enable.
  input wire logic sample_strobe, // Strobe.
  input wire logic [7:0] delta_x, // X change.
  input wire logic [7:0] delta_y, // Y change.
  input wire logic [7:0] delta_z, // Z change.
  input wire logic freefall_event, // Free fall.
  input wire logic buf_half_full, // Half.
  input wire logic buf_tq_full, // Three quarter.
  input wire logic int_pin, // Interrupt.
  input wire logic motion_irq, // Motion.
  input wire logic buf_store_x, // Store X.
  input wire logic buf_store_y, // Store Y.
  input wire logic buf_store_z // Store Z.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] rise_q;
  logic [14:0] bits_q;
  // Counts rises and gathers the returned bits of the open frame.
  always_ff @(posedge sck or posedge chip_select_n) begin
    if (chip_select_n) begin
      rise_q <= 5'h00;
      bits_q <= 15'h0000;
    end else begin
      rise_q <= rise_q + 5'h01;
      bits_q <= {bits_q[13:0], miso_o};
    end
  end
  sequence s_launch;
    !chip_select_n && !$past(chip_select_n) && $changed(miso_o);
  endsequence
  chk_idle_released: assert property (
    @(posedge core_clk) disable iff (!rst_n) chip_select_n |-> miso_oe_n && !miso_o)
    else $error("miso not released");
  chk_frame_driven: assert property (
    @(posedge core_clk) disable iff (!rst_n) !chip_select_n |-> !miso_oe_n)
    else $error("miso not driven in frame");
  chk_launch_fall: assert property (
    @(posedge core_clk) disable iff (!rst_n) s_launch |-> !sck)
    else $error("miso changed off the falling edge");
  chk_marker_one: assert property (
    @(posedge sck) disable iff (!rst_n || chip_select_n) rise_q == 5'h06 |-> miso_o)
    else $error("marker bit not one");
  chk_status_zeros: assert property (
    @(posedge sck) disable iff (!rst_n || chip_select_n)
    rise_q inside {5'h00, 5'h02, 5'h03, 5'h04, 5'h05} |-> !miso_o)
    else $error("status byte bit not zero");
  chk_odd_parity: assert property (
    @(posedge sck) disable iff (!rst_n || chip_select_n)
    rise_q == 5'h0F |-> ^{bits_q[7:0], miso_o})
    else $error("parity not odd");
  chk_store_cause: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (buf_store_x || buf_store_y || buf_store_z) |-> $past(sample_strobe))
    else $error("store without strobe");
  chk_motion_quiet: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (delta_x == 8'h00 && delta_y == 8'h00 && delta_z == 8'h00) |=> !motion_irq)
    else $error("motion hit on zero change");
endmodule

bind ssp_top ssp_top_asserts i_chk (.core_clk(core_clk), .rst_n(rst_n), .sck(sck),
  .chip_select_n(chip_select_n), .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n),
  .sample_strobe(sample_strobe), .delta_x(delta_x), .delta_y(delta_y), .delta_z(delta_z),
  .freefall_event(freefall_event), .buf_half_full(buf_half_full), .buf_tq_full(buf_tq_full),
  .int_pin(int_pin), .motion_irq(motion_irq), .buf_store_x(buf_store_x),
  .buf_store_y(buf_store_y), .buf_store_z(buf_store_z));
